/* File: core/sdwb_params.svh */
// Constants for the write-burst engine of the DDR2 device model
`ifndef SDWB_PARAMS_SVH
`define SDWB_PARAMS_SVH

`define SDWB_BANK_W      2
`define SDWB_COL_W       12
`define SDWB_IDX_W       3
`define SDWB_LAT_W       4
`define SDWB_PAIRS_BL4   3'h2
`define SDWB_PAIRS_BL8   3'h4
`define SDWB_TRUNC_GAP   3'h2
`define SDWB_TRUNC_PAIRS 3'h2
`define SDWB_GAP_SAT     3'h7
`define SDWB_GAP_RST     3'h7
`define SDWB_IDX_RST     3'h0
`define SDWB_LAT_RST     4'h0
`define SDWB_DW_MAX      32

`endif

/* File: core/sdwb_pkg.sv */
// Types shared by the write-burst engine files
`include "sdwb_params.svh"

package sdwb_pkg;

    typedef enum logic [1:0] {
        SDWB_IDLE = 2'b00,
        SDWB_LAT  = 2'b01,
        SDWB_DATA = 2'b10
    } sdwb_state_t;

    typedef struct packed {
        logic [`SDWB_BANK_W-1:0] bank;
        logic [`SDWB_COL_W-1:0]  col;
        logic                    ap;
        logic [`SDWB_IDX_W-1:0]  quota;
    } sdwb_desc_t;

endpackage

/* File: core/sdwb_pair_if.sv */
// Carrier of captured data pairs from the strobe domain to the clock domain
`timescale 1ns/1ps
`default_nettype none

interface sdwb_pair_if #(
    parameter int DW = 8
);
    logic            clr;
    logic            tog;
    logic [2*DW-1:0] data;
    logic [1:0]      mask;

    modport cap (
        input  clr,
        output tog,
        output data,
        output mask
    );

    modport core (
        output clr,
        input  tog,
        input  data,
        input  mask
    );
endinterface

`default_nettype wire

/* File: core/sdwb_strobe_cap.sv */
// Strobe-domain capture of write data pairs
`timescale 1ns/1ps
`default_nettype none

module sdwb_strobe_cap #(
    parameter int DW = 8
) (
    // Link
    input  wire logic          wstrobe_clk_i,
    input  wire logic [DW-1:0] dq_i,
    input  wire logic          data_mask_input_i,
    // Pair carrier
    sdwb_pair_if.cap           pair
);

    logic [DW-1:0] rise_data_q;
    logic          rise_mask_q;

    // Strobe stops between frames, so clear is asynchronous
    always_ff @(posedge wstrobe_clk_i or posedge pair.clr) begin
        if (pair.clr) begin
            rise_data_q <= '0;
            rise_mask_q <= 1'b0;
        end else begin
            rise_data_q <= dq_i;
            rise_mask_q <= data_mask_input_i;
        end
    end

    // Falling edge completes a pair; data held until the next pair
    always_ff @(negedge wstrobe_clk_i or posedge pair.clr) begin
        if (pair.clr) begin
            pair.data <= '0;
            pair.mask <= 2'h0;
            pair.tog  <= 1'b0;
        end else begin
            pair.data <= {dq_i, rise_data_q};
            pair.mask <= {data_mask_input_i, rise_mask_q};
            pair.tog  <= ~pair.tog;
        end
    end

endmodule

`default_nettype wire

/* File: core/sdwb_write_burst.sv */
// Write-burst engine: command timing, burst tracking and data write-out
`timescale 1ns/1ps
`default_nettype none
`include "sdwb_params.svh"

module sdwb_write_burst
    import sdwb_pkg::*;
#(
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    srst_i,
    input  wire logic                    clk_en_i,
    // Link
    input  wire logic                    wstrobe_clk_i,
    input  wire logic [DW-1:0]           dq_i,
    input  wire logic                    data_mask_input_i,
    output logic      [DW-1:0]           dq_o,
    output logic                         dq_oe_o,
    // Command
    input  wire logic                    cmd_write_i,
    input  wire logic [`SDWB_BANK_W-1:0] cmd_bank_i,
    input  wire logic [`SDWB_COL_W-1:0]  cmd_col_i,
    input  wire logic                    precharge_select_line_i,
    // Configuration
    input  wire logic [2:0]              added_latency_i,
    input  wire logic [2:0]              column_access_latency_i,
    input  wire logic                    burst_length_eight_i,
    // Array write port
    output logic                         mem_wr_o,
    output logic      [`SDWB_BANK_W-1:0] mem_bank_o,
    output logic      [`SDWB_COL_W-1:0]  mem_col_o,
    output logic      [`SDWB_COL_W-1:0]  mem_col2_o,
    output logic      [2*DW-1:0]         mem_data_o,
    output logic      [1:0]              mem_byte_wr_o,
    // Status
    output logic                         row_close_o,
    output logic      [`SDWB_BANK_W-1:0] row_close_bank_o,
    output logic                         burst_busy_o,
    output logic      [`SDWB_LAT_W-1:0]  write_latency_o,
    output logic                         discard_o,
    output logic                         spacing_err_o
);

    generate
        if (DW < 1 || DW > `SDWB_DW_MAX) begin : g_bad_dw
            $error("sdwb_write_burst: DW out of range");
        end
    endgenerate

    // Column of an element within the wrapping burst window
    function automatic logic [`SDWB_COL_W-1:0] burst_col(
        input logic [`SDWB_COL_W-1:0] c,
        input logic [2:0]             off,
        input logic                   bl8
    );
        logic [2:0] lo8;
        logic [1:0] lo4;
        lo8 = c[2:0] + off;
        lo4 = c[1:0] + off[1:0];
        if (bl8) begin
            burst_col = {c[`SDWB_COL_W-1:3], lo8};
        end else begin
            burst_col = {c[`SDWB_COL_W-1:2], lo4};
        end
    endfunction

    sdwb_pair_if #(.DW(DW)) pair_if ();

    sdwb_strobe_cap #(.DW(DW)) u_cap (
        .wstrobe_clk_i     (wstrobe_clk_i),
        .dq_i              (dq_i),
        .data_mask_input_i (data_mask_input_i),
        .pair              (pair_if.cap)
    );

    // Write path only: pins never driven
    assign dq_o    = '0;
    assign dq_oe_o = 1'b0;

    // Crossing of the pair toggle
    logic clr_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;

    assign pair_if.clr = clr_q;

    always_ff @(posedge mclk_i) begin
        clr_q <= srst_i;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else if (clk_en_i) begin
            tog_s1_q <= pair_if.tog;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    wire pair_evt = tog_s2_q ^ tog_s3_q;

    // Latency and burst decode
    wire [`SDWB_LAT_W-1:0] lat_sum   = {1'b0, added_latency_i} + {1'b0, column_access_latency_i};
    wire [`SDWB_LAT_W-1:0] wl_c      = (lat_sum == `SDWB_LAT_RST) ? `SDWB_LAT_RST
                                                                   : lat_sum - 4'h1;
    wire [`SDWB_IDX_W-1:0] pairs_full = burst_length_eight_i ? `SDWB_PAIRS_BL8 : `SDWB_PAIRS_BL4;

    // Burst tracking state
    sdwb_state_t            state_q;
    sdwb_state_t            state_d;
    sdwb_desc_t             cur_q;
    sdwb_desc_t             cur_d;
    sdwb_desc_t             pend_q;
    sdwb_desc_t             pend_d;
    logic                   pend_v_q;
    logic                   pend_v_d;
    logic [`SDWB_IDX_W-1:0] idx_q;
    logic [`SDWB_IDX_W-1:0] idx_d;
    logic [`SDWB_LAT_W-1:0] lat_q;
    logic [`SDWB_LAT_W-1:0] lat_d;
    logic [`SDWB_LAT_W-1:0] plat_q;
    logic [`SDWB_LAT_W-1:0] plat_d;
    logic [2:0]             gap_q;
    logic                   last_pair;

    sdwb_desc_t new_desc;
    // One driver for the whole descriptor
    assign new_desc = '{bank: cmd_bank_i, col: cmd_col_i, ap: precharge_select_line_i, quota: pairs_full};

    wire        busy      = (state_q != SDWB_IDLE);
    sdwb_desc_t last_desc;
    assign last_desc = pend_v_q ? pend_q : cur_q;

    // Truncation only of a full eight-burst, no auto precharge, two clocks on
    wire trunc_ok  = cmd_write_i && busy && burst_length_eight_i
                     && (gap_q == `SDWB_TRUNC_GAP) && !last_desc.ap
                     && (last_desc.quota == `SDWB_PAIRS_BL8);
    wire spacing_bad = cmd_write_i && busy && (gap_q < pairs_full) && !trunc_ok;
    wire pair_take = pair_evt && (state_q == SDWB_DATA);
    wire pair_drop = pair_evt && (state_q != SDWB_DATA);

    always_comb begin
        state_d   = state_q;
        cur_d     = cur_q;
        pend_d    = pend_q;
        pend_v_d  = pend_v_q;
        idx_d     = idx_q;
        lat_d     = lat_q;
        plat_d    = plat_q;
        last_pair = 1'b0;
        if (lat_q != `SDWB_LAT_RST) begin
            lat_d = lat_q - 4'h1;
        end
        if (plat_q != `SDWB_LAT_RST) begin
            plat_d = plat_q - 4'h1;
        end
        if (state_q == SDWB_LAT && lat_q == `SDWB_LAT_RST) begin
            state_d = SDWB_DATA;
        end
        // Truncated burst ends after four elements
        if (trunc_ok) begin
            if (pend_v_q) begin
                pend_d.quota = `SDWB_TRUNC_PAIRS;
            end else begin
                cur_d.quota = `SDWB_TRUNC_PAIRS;
            end
        end
        if (pair_take) begin
            idx_d = idx_q + 3'h1;
            if (idx_q + 3'h1 >= cur_d.quota) begin
                last_pair = 1'b1;
                idx_d     = `SDWB_IDX_RST;
                if (pend_v_q) begin
                    // Next burst's data follows directly, or after the latency left on its count
                    cur_d    = pend_d;
                    pend_v_d = 1'b0;
                    lat_d    = plat_d;
                    state_d  = (plat_d == `SDWB_LAT_RST) ? SDWB_DATA : SDWB_LAT;
                end else begin
                    state_d = SDWB_IDLE;
                end
            end
        end
        if (cmd_write_i) begin
            if (state_d == SDWB_IDLE && !pend_v_d) begin
                cur_d   = new_desc;
                idx_d   = `SDWB_IDX_RST;
                lat_d   = wl_c;
                state_d = (wl_c == `SDWB_LAT_RST) ? SDWB_DATA : SDWB_LAT;
            end else begin
                // A third queued write overwrites the pending one
                pend_d   = new_desc;
                pend_v_d = 1'b1;
                plat_d   = wl_c;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q  <= SDWB_IDLE;
            cur_q    <= '0;
            pend_q   <= '0;
            pend_v_q <= 1'b0;
            idx_q    <= `SDWB_IDX_RST;
            lat_q    <= `SDWB_LAT_RST;
            plat_q   <= `SDWB_LAT_RST;
        end else if (clk_en_i) begin
            state_q  <= state_d;
            cur_q    <= cur_d;
            pend_q   <= pend_d;
            pend_v_q <= pend_v_d;
            idx_q    <= idx_d;
            lat_q    <= lat_d;
            plat_q   <= plat_d;
        end
    end

    // Clocks since the last write, saturating
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            gap_q <= `SDWB_GAP_RST;
        end else if (clk_en_i) begin
            if (cmd_write_i) begin
                gap_q <= 3'h1;
            end else if (gap_q != `SDWB_GAP_SAT) begin
                gap_q <= gap_q + 3'h1;
            end
        end
    end

    // Array write-out, one pair per strobe cycle
    wire [2:0] off0 = {idx_q[1:0], 1'b0};
    wire [2:0] off1 = {idx_q[1:0], 1'b1};

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mem_wr_o      <= 1'b0;
            mem_bank_o    <= '0;
            mem_col_o     <= '0;
            mem_col2_o    <= '0;
            mem_data_o    <= '0;
            mem_byte_wr_o <= 2'h0;
        end else if (clk_en_i) begin
            mem_wr_o <= pair_take;
            if (pair_take) begin
                mem_bank_o    <= cur_q.bank;
                mem_col_o     <= burst_col(cur_q.col, off0, burst_length_eight_i);
                mem_col2_o    <= burst_col(cur_q.col, off1, burst_length_eight_i);
                mem_data_o    <= pair_if.data;
                mem_byte_wr_o <= ~pair_if.mask;
            end
        end
    end

    // Status
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            row_close_o      <= 1'b0;
            row_close_bank_o <= '0;
            burst_busy_o     <= 1'b0;
            write_latency_o  <= `SDWB_LAT_RST;
            discard_o        <= 1'b0;
            spacing_err_o    <= 1'b0;
        end else if (clk_en_i) begin
            row_close_o     <= last_pair && cur_q.ap;
            if (last_pair && cur_q.ap) begin
                row_close_bank_o <= cur_q.bank;
            end
            burst_busy_o    <= (state_d != SDWB_IDLE);
            write_latency_o <= wl_c;
            discard_o       <= pair_drop;
            spacing_err_o   <= spacing_bad;
        end
    end

endmodule

`default_nettype wire

/* File: verification/sdwb_write_burst_sva.sv */
// Port-level checks of the write-burst engine
`timescale 1ns/1ps
`default_nettype none
`include "sdwb_params.svh"

module sdwb_write_burst_sva #(
    parameter int DW = 8
) (
    // Clock, reset and inputs
    input wire logic                   mclk_i,
    input wire logic                   srst_i,
    input wire logic                   clk_en_i,
    input wire logic                   cmd_write_i,
    input wire logic                   precharge_select_line_i,
    input wire logic [2:0]             added_latency_i,
    input wire logic [2:0]             column_access_latency_i,
    input wire logic                   burst_length_eight_i,
    // Outputs watched
    input wire logic [DW-1:0]          dq_o,
    input wire logic                   dq_oe_o,
    input wire logic                   mem_wr_o,
    input wire logic                   row_close_o,
    input wire logic                   burst_busy_o,
    input wire logic [`SDWB_LAT_W-1:0] write_latency_o,
    input wire logic                   discard_o,
    input wire logic                   spacing_err_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    logic [3:0] wl_sum;
    assign wl_sum = {1'b0, added_latency_i} + {1'b0, column_access_latency_i};

    sequence s_quiet_write;
        cmd_write_i && clk_en_i && !burst_busy_o;
    endsequence
    sequence s_trunc;
        cmd_write_i && burst_length_eight_i && !precharge_select_line_i ##2 cmd_write_i;
    endsequence

    AST_PINS_IDLE: assert property (!dq_oe_o && dq_o == '0)
        else $error("data pins driven");
    AST_WL_VALUE: assert property (clk_en_i && !$past(srst_i) && $stable(added_latency_i)
        && $stable(column_access_latency_i)
        |=> write_latency_o == ($past(wl_sum) == 4'h0 ? 4'h0 : $past(wl_sum) - 4'h1))
        else $error("write latency wrong");
    AST_BUSY_ON_WRITE: assert property (cmd_write_i && clk_en_i |=> burst_busy_o)
        else $error("busy not raised by write");
    AST_NO_EARLY_PAIR: assert property (s_quiet_write |=> !mem_wr_o [*2])
        else $error("pair written before data");
    AST_CLOSE_WITH_LAST: assert property (row_close_o |-> mem_wr_o ##1 !row_close_o)
        else $error("row close not with last pair");
    AST_DROP_NOT_WRITTEN: assert property (discard_o |-> !mem_wr_o)
        else $error("dropped pair written");
    AST_BUSY_ENDS_ON_PAIR: assert property ($fell(burst_busy_o)
        |-> (mem_wr_o || $past(mem_wr_o)) or (##1 mem_wr_o))
        else $error("burst ended without pair");
    AST_SPACING_FLAG: assert property (cmd_write_i && $past(cmd_write_i) |=> spacing_err_o)
        else $error("close writes not flagged");
    AST_TRUNC_LEGAL: assert property (s_trunc |=> !spacing_err_o)
        else $error("legal truncation flagged");
endmodule

bind sdwb_write_burst sdwb_write_burst_sva #(.DW(DW)) u_sdwb_write_burst_sva (
    .mclk_i, .srst_i, .clk_en_i, .cmd_write_i, .precharge_select_line_i, .added_latency_i,
    .column_access_latency_i, .burst_length_eight_i, .dq_o, .dq_oe_o, .mem_wr_o, .row_close_o,
    .burst_busy_o, .write_latency_o, .discard_o, .spacing_err_o
);

`default_nettype wire

/* File: verification/sdwb_ctrl_model.sv */
// Behavioural controller driving strobe, write data and mask
`timescale 1ns/1ps
`default_nettype none

module sdwb_ctrl_model #(
    parameter int DW = 8
) (
    // Link
    output var logic          wstrobe_clk_o,
    output var logic [DW-1:0] dq_o,
    output var logic          mask_o
);
    initial begin
        wstrobe_clk_o = 1'b0;
        dq_o = '0;
        mask_o = 1'b0;
    end

    // Element i carries base+i; whole pairs only, pairs back to back
    task automatic send(input int np, input logic [DW-1:0] base, input logic [15:0] msk);
        for (int i = 0; i < 2 * np; i++) begin
            dq_o = base + DW'(i);
            mask_o = msk[i];
            #40;
            wstrobe_clk_o = ~wstrobe_clk_o;
            #40;
        end
        // Strobe parked low; lines no longer hold the last element
        dq_o = ~dq_o;
        mask_o = ~mask_o;
    endtask
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the write-burst engine
`timescale 1ns/1ps
`default_nettype none
`include "sdwb_params.svh"

module testbench;
    logic                    mclk_i = 1'b0;
    logic                    srst_i = 1'b1;
    logic                    clk_en_i = 1'b1;
    logic                    cmd_write_i = 1'b0;
    logic [1:0]              cmd_bank_i = '0;
    logic [11:0]             cmd_col_i = '0;
    logic                    precharge_select_line_i = 1'b0;
    logic [2:0]              added_latency_i = '0;
    logic [2:0]              column_access_latency_i = 3'h3;
    logic                    burst_length_eight_i = 1'b0;
    wire logic               wstrobe_clk_i;
    wire logic [7:0]         dq_i;
    wire logic               data_mask_input_i;
    wire logic [7:0]         dq_o;
    wire logic               dq_oe_o, mem_wr_o, row_close_o, burst_busy_o, discard_o, spacing_err_o;
    wire logic [1:0]         mem_bank_o, mem_byte_wr_o, row_close_bank_o;
    wire logic [11:0]        mem_col_o, mem_col2_o;
    wire logic [15:0]        mem_data_o;
    wire logic [3:0]         write_latency_o;
    int                      fail_count, n_checks, n_disc, n_sp, wl;
    logic [7:0]              base = 8'h30;
    logic [15:0]             msk;
    logic [44:0]             expq[$];
    logic [44:0]             gotq[$];

    always #20 mclk_i = ~mclk_i;

    sdwb_write_burst #(.DW(8)) u_sdwb_write_burst (
        .mclk_i, .srst_i, .clk_en_i, .wstrobe_clk_i, .dq_i, .data_mask_input_i, .dq_o, .dq_oe_o,
        .cmd_write_i, .cmd_bank_i, .cmd_col_i, .precharge_select_line_i, .added_latency_i,
        .column_access_latency_i, .burst_length_eight_i, .mem_wr_o, .mem_bank_o, .mem_col_o, .mem_col2_o,
        .mem_data_o, .mem_byte_wr_o, .row_close_o, .row_close_bank_o, .burst_busy_o, .write_latency_o,
        .discard_o, .spacing_err_o
    );
    sdwb_ctrl_model #(.DW(8)) u_sdwb_ctrl_model (
        .wstrobe_clk_o(wstrobe_clk_i), .dq_o(dq_i), .mask_o(data_mask_input_i)
    );

    always @(posedge mclk_i) begin
        if (mem_wr_o === 1'b1)
            gotq.push_back({row_close_o, mem_bank_o, mem_col_o, mem_col2_o, mem_byte_wr_o, mem_data_o});
        if (discard_o === 1'b1)
            n_disc++;
        if (spacing_err_o === 1'b1)
            n_sp++;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [44:0] seen, input logic [44:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs change 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic cfg(input int a, input int c, input logic b8);
        added_latency_i = 3'(a);
        column_access_latency_i = 3'(c);
        burst_length_eight_i = b8;
        wl = (a + c == 0) ? 0 : a + c - 1;
        tick(2);
    endtask

    task automatic wr(input logic [1:0] b, input logic [11:0] c, input logic ap);
        cmd_write_i = 1'b1;
        cmd_bank_i = b;
        cmd_col_i = c;
        precharge_select_line_i = ap;
        tick(1);
        cmd_write_i = 1'b0;
    endtask

    // Columns wrap inside the burst-sized block
    function automatic logic [11:0] ecol(input logic [11:0] c, input int k);
        return burst_length_eight_i ? {c[11:3], c[2:0] + 3'(k)} : {c[11:2], c[1:0] + 2'(k)};
    endfunction

    task automatic exp_b(input logic ap, input logic [1:0] b, input logic [11:0] c, input int np, input int e0);
        int e;
        for (int p = 0; p < np; p++) begin
            e = e0 + 2 * p;
            expq.push_back({ap && p == np - 1, b, ecol(c, 2 * p), ecol(c, 2 * p + 1), ~msk[e + 1], ~msk[e],
                            base + 8'(e + 1), base + 8'(e)});
        end
    endtask

    task automatic burst(input int np);
        // Only idle cycles follow: no read, precharge or activate is ever issued
        u_sdwb_ctrl_model.send(np, base, msk);
        for (int i = 0; i < 400 && gotq.size() < expq.size(); i++)
            tick(1);
        tick(8);
        check("pair count", 45'(gotq.size()), 45'(expq.size()));
        if (gotq.size() < expq.size())
            complete_run();
        while (expq.size() > 0 && gotq.size() > 0)
            check("pair", gotq.pop_front(), expq.pop_front());
        check("busy", 45'(burst_busy_o), 45'(0));
        gotq.delete();
        expq.delete();
    endtask

    task automatic sc_latency();
        for (int i = 0; i < 8; i++) begin
            cfg(i, (i * 3) % 8, 1'b0);
            check("write latency", 45'(write_latency_o), 45'(wl));
        end
    endtask

    // Enable low freezes the latency register while its inputs move
    task automatic sc_freeze();
        cfg(1, 3, 1'b0);
        clk_en_i = 1'b0;
        added_latency_i = 3'h2;
        tick(3);
        check("frozen latency", 45'(write_latency_o), 45'(3));
        clk_en_i = 1'b1;
        tick(2);
        check("thawed latency", 45'(write_latency_o), 45'(4));
    endtask

    task automatic sc_ap_mask();
        cfg(0, 3, 1'b0);
        msk = 16'h0006;
        wr(2'h1, 12'h0a6, 1'b1);
        tick(wl);
        exp_b(1'b1, 2'h1, 12'h0a6, 2, 0);
        burst(2);
        check("close bank", 45'(row_close_bank_o), 45'(1));
    endtask

    task automatic sc_back_to_back();
        cfg(1, 3, 1'b0);
        msk = 16'h0080;
        n_sp = 0;
        wr(2'h0, 12'h010, 1'b0);
        tick(1);
        wr(2'h2, 12'h3ff, 1'b1);
        tick(wl);
        exp_b(1'b0, 2'h0, 12'h010, 2, 0);
        exp_b(1'b1, 2'h2, 12'h3ff, 2, 4);
        burst(4);
        check("spacing flags", 45'(n_sp), 45'(0));
    endtask

    task automatic sc_truncate();
        cfg(0, 4, 1'b1);
        msk = 16'h0400;
        n_sp = 0;
        wr(2'h0, 12'h005, 1'b0);
        tick(1);
        wr(2'h3, 12'h0fe, 1'b1);
        tick(wl);
        exp_b(1'b0, 2'h0, 12'h005, 2, 0);
        exp_b(1'b1, 2'h3, 12'h0fe, 4, 4);
        burst(6);
        check("spacing flags", 45'(n_sp), 45'(0));
        check("close bank", 45'(row_close_bank_o), 45'(3));
    endtask

    // Writes one cycle apart are accepted but flagged
    task automatic sc_spacing();
        cfg(0, 3, 1'b0);
        n_sp = 0;
        cmd_write_i = 1'b1;
        tick(1);
        cmd_bank_i = 2'h1;
        tick(1);
        cmd_write_i = 1'b0;
        tick(2);
        check("spacing flags", 45'(n_sp), 45'(1));
        u_sdwb_ctrl_model.send(4, base, 16'h0000);
        tick(10);
        gotq.delete();
        check("busy", 45'(burst_busy_o), 45'(0));
    endtask

    task automatic sc_discard();
        n_disc = 0;
        u_sdwb_ctrl_model.send(1, base, 16'h0000);
        tick(8);
        check("dropped pairs", 45'(n_disc), 45'(1));
        check("stray writes", 45'(gotq.size()), 45'(0));
        check("pin enable", 45'(dq_oe_o), 45'(0));
    endtask

    initial begin
        tick(6);
        srst_i = 1'b0;
        tick(2);
        sc_latency();
        sc_freeze();
        sc_ap_mask();
        sc_back_to_back();
        sc_truncate();
        sc_spacing();
        sc_discard();
        complete_run();
    end
endmodule

`default_nettype wire
